// *** rtl/timer_regs.svh ***
/*
 * Register offsets, field positions, reset values and divider figures of the triple timer.
 * Assumes an 8-bit register port whose address splits into channel index and register slot.
 */
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH

// =====================================
// register slots inside one channel window
`define OFF_CTRL_HI     3'h0
`define OFF_CTRL_LO     3'h1
`define OFF_A_HI        3'h2
`define OFF_A_LO        3'h3
`define OFF_B_HI        3'h4
`define OFF_B_LO        3'h5
`define OFF_CNT_HI      3'h6
`define OFF_CNT_LO      3'h7

// =====================================
// shared registers above the three channel windows
`define OFF_PORT_FN     8'h18
`define OFF_STATUS      8'h19

// =====================================
// field positions
`define CTRL_EN_BIT     7
`define CTRL_MODE_HI    5
`define CTRL_MODE_LO    4
`define CTRL_CK_HI      2
`define CTRL_CK_LO      0
`define STAT_CAP_LSB    3

// =====================================
// reset values and writable masks
`define RST_BYTE        8'h00
`define RST_WORD        16'h0000
`define RST_A_WORD      16'hFFFF
`define MASK_CTRL_HI    8'hB0
`define MASK_CTRL_LO    8'h07
`define MASK_PORT_FN    8'h3F
`define FN_OUTPUT       2'h3
`define FN_CAPTURE      2'h0

// =====================================
// prescaler: divide-by as a power of two
`define PRE_WIDTH       11
`define DIV_LOG_C4      6
`define DIV_LOG_C5      9
`define DIV_LOG_C6      11
`define DIV_LOG_DE4     5
`define DIV_LOG_DE5     7
`define DIV_LOG_DE6     9

`endif

// *** rtl/timer_pkg.sv ***
/*
 * Types shared by the triple timer and its channel core.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package timer_pkg;

	// =====================================
	// operating modes, in order of their two-bit code
	typedef enum logic [1:0] {MODE_TIMER, MODE_CAPTURE, MODE_ONESHOT, MODE_REPEAT} mode_e;

	// run state of a channel counter
	typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DONE} run_state_e;

	typedef logic [15:0] count_t;
	typedef logic [7:0]  byte_t;

endpackage

// *** rtl/timer_chan_if.sv ***
/*
 * Bundle between the register side of the timer and one channel core.
 * Assumes the channel core samples everything on the system clock.
 */
`timescale 1ns/1ps
interface timer_chan_if;
	import timer_pkg::*;

	// =====================================
	// control toward the channel
	logic   enable;
	mode_e  mode;
	logic   tick;
	count_t a_data;
	count_t b_data;

	// state from the channel
	count_t count;
	logic   match;
	logic   cmp_level;
	logic   pulse_level;

	modport chan (input enable, mode, tick, a_data, b_data, output count, match, cmp_level, pulse_level);
	modport ctl  (output enable, mode, tick, a_data, b_data, input count, match, cmp_level, pulse_level);
endinterface

// *** rtl/timer_channel.sv ***
/*
 * One 16-bit channel core: counter, A/B match, compare toggle and pulse waveform.
 * Assumes ticks are one-cycle pulses already qualified by the clock enable domain.
 */
`timescale 1ns/1ps
module timer_channel (
	// clock and reset
	input  wire logic sys_clk_in,
	input  wire logic rst_in,
	input  wire logic clk_en_in,
	// register side
	timer_chan_if.chan bus
);
	import timer_pkg::*;

	// =====================================
	// state
	run_state_e st_q;
	count_t     cnt_q;
	logic       match_q;
	logic       cmp_q;
	logic       pls_q;

	// match decode and mode classes
	wire hit_a   = (cnt_q == bus.a_data);
	wire hit_b   = (cnt_q == bus.b_data);
	wire is_ppg  = (bus.mode == MODE_ONESHOT) || (bus.mode == MODE_REPEAT);
	wire one_sht = (bus.mode == MODE_ONESHOT);

	// counter, period end, compare toggle and pulse shaping
	always_ff @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			st_q    <= ST_IDLE;
			cnt_q   <= 16'h0000;
			match_q <= 1'b0;
			cmp_q   <= 1'b0;
			pls_q   <= 1'b0;
		end
		else if (clk_en_in)
		begin
			match_q <= 1'b0;
			if (!bus.enable)
			begin
				st_q  <= ST_IDLE;
				cnt_q <= 16'h0000;
				cmp_q <= 1'b0;
				pls_q <= 1'b0;
			end
			else
			begin
				case (st_q)
					ST_IDLE:
					begin
						st_q  <= ST_RUN;
						cnt_q <= 16'h0000;
						pls_q <= is_ppg;
					end
					ST_RUN:
					begin
						if (bus.tick && hit_a)
						begin
							cnt_q   <= 16'h0000;
							match_q <= 1'b1;
							if (bus.mode == MODE_TIMER)
								cmp_q <= ~cmp_q;
							if (one_sht)
							begin
								st_q  <= ST_DONE;
								pls_q <= 1'b0;
							end
							else
								pls_q <= is_ppg;
						end
						else if (bus.tick)
						begin
							cnt_q <= cnt_q + 16'h0001;
							if (hit_b && is_ppg)
								pls_q <= 1'b0;
						end
					end
					ST_DONE:
						st_q <= ST_DONE;
					default:
						st_q <= ST_IDLE;
				endcase
			end
		end
	end

	// state back to the register side
	assign bus.count       = cnt_q;
	assign bus.match       = match_q;
	assign bus.cmp_level   = cmp_q;
	assign bus.pulse_level = pls_q;

endmodule

// *** rtl/triple_timer.sv ***
/*
 * Three 16-bit timer channels (C, D, E) with register port, prescaler and pin handling.
 * Assumes a single 125 MHz system clock, pins from outside that clock, and a master
 * that issues one-cycle read or write strobes and takes read data one cycle later.
 */
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "timer_regs.svh"

// Behaviour
// - each channel: 16-bit A and B data in byte halves, two control halves, clock mux
// - channel C clocks from fx/1,2,4,8,64,512,2048 or external count pin
// - channel C capture mode copies counter into B on its trigger pin
// - channel C timer mode toggles compare pin at each A match
// - channel C pulse modes drive waveform on its pulse pin
// - mode 00 timer, 01 capture, 10 one-shot, 11 repeat; pin field 11 or 00
// - channel D clocks from fx/1,2,4,8,32,128,512 or channel C A-match
// - channel D capture mode copies counter into B on its trigger pin
// - channel D timer mode toggles compare pin at each A match
// - channel D pulse modes drive waveform on its pulse pin
// - channel D shares mode codes; pin field is bits 3:2
// - channel E clocks from fx/1,2,4,8,32,128,512 or internal fast RC clock
// - channel E capture mode copies counter into B on its trigger pin
// - channel E timer mode toggles compare pin on A match
// - channel E pulse modes drive waveform on its pulse pin
// - channel E shares mode codes; pin field is bits 5:4
// - channel C pin field is bits 1:0; enable bit must be set to run
module triple_timer (
	// clock, reset, enable
	input  wire logic             sys_clk_in,
	input  wire logic             rst_in,
	input  wire logic             clk_en_in,
	// register port
	input  wire logic [7:0]       reg_addr_in,
	input  wire timer_pkg::byte_t reg_wdata_in,
	input  wire logic             reg_wr_in,
	input  wire logic             reg_rd_in,
	output timer_pkg::byte_t      reg_rdata_out,
	// clock source pins
	input  wire logic             chan_c_external_count_clock_in,
	input  wire logic             internal_fast_rc_clock_in,
	// capture trigger pins
	input  wire logic             chan_c_capture_trigger_in,
	input  wire logic             chan_d_capture_trigger_in,
	input  wire logic             chan_e_capture_trigger_in,
	// waveform pins
	output logic                  chan_c_compare_out,
	output logic                  chan_d_compare_out,
	output logic                  chan_e_compare_out,
	output logic                  chan_c_pulse_out,
	output logic                  chan_d_pulse_out,
	output logic                  chan_e_pulse_out
);
	import timer_pkg::*;

	localparam int NCH  = 3;
	localparam int NPIN = 5;

	// =====================================
	// helpers

	// prescaler tap: high once every 2^lg cycles
	function automatic logic pre_tick(input logic [`PRE_WIDTH-1:0] pre, input int lg);
		logic [`PRE_WIDTH-1:0] m;
		m = `PRE_WIDTH'((1 << lg) - 1);
		return &(pre | ~m);
	endfunction

	// divider power for a channel's clock select; channel 0 uses the wide set
	function automatic int div_log(input int ch, input logic [2:0] sel);
		int r;
		r = 0;
		case (sel)
			3'h1:    r = 1;
			3'h2:    r = 2;
			3'h3:    r = 3;
			3'h4:    r = (ch == 0) ? `DIV_LOG_C4 : `DIV_LOG_DE4;
			3'h5:    r = (ch == 0) ? `DIV_LOG_C5 : `DIV_LOG_DE5;
			3'h6:    r = (ch == 0) ? `DIV_LOG_C6 : `DIV_LOG_DE6;
			default: r = 0;
		endcase
		return r;
	endfunction

	// =====================================
	// pin synchronisers
	// order: ext count, rc clock, trigger C, D, E

	logic [NPIN-1:0] pin_s1_q;
	logic [NPIN-1:0] pin_s2_q;
	logic [NPIN-1:0] pin_s3_q;

	wire [NPIN-1:0] pin_raw = {chan_e_capture_trigger_in, chan_d_capture_trigger_in,
		chan_c_capture_trigger_in, internal_fast_rc_clock_in, chan_c_external_count_clock_in};

	// two stages then an edge-detect stage
	always_ff @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			pin_s1_q <= '0;
			pin_s2_q <= '0;
			pin_s3_q <= '0;
		end
		else if (clk_en_in)
		begin
			pin_s1_q <= pin_raw;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
		end
	end

	// rising edges of the synchronised pins
	wire [NPIN-1:0] pin_rise = pin_s2_q & ~pin_s3_q;
	wire            ext_tick = pin_rise[0];
	wire            rc_tick  = pin_rise[1];

	// =====================================
	// prescaler on fx

	logic [`PRE_WIDTH-1:0] pre_q;

	// free-running divide chain
	always_ff @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
			pre_q <= '0;
		else if (clk_en_in)
			pre_q <= pre_q + `PRE_WIDTH'(1);
	end

	// =====================================
	// register decode

	wire [1:0] ch_idx   = reg_addr_in[4:3];
	wire       chan_hit = (reg_addr_in[7:5] == 3'h0) && (ch_idx != 2'h3);
	wire [2:0] slot     = reg_addr_in[2:0];
	wire [7:0] slot_dec = 8'h01 << slot;
	wire       wr_fn    = reg_wr_in && (reg_addr_in == `OFF_PORT_FN);
	wire       wr_stat  = reg_wr_in && (reg_addr_in == `OFF_STATUS);

	// =====================================
	// shared registers

	byte_t port0_function_select_high_q;
	logic [2:0] match_flag_q;
	logic [2:0] cap_flag_q;

	// per-channel arrays
	byte_t  ctrl_hi_q [NCH];
	byte_t  ctrl_lo_q [NCH];
	count_t a_q [NCH];
	count_t b_q [NCH];
	count_t count_w [NCH];
	logic   match_w [NCH];
	logic   cmp_w [NCH];
	logic   pls_w [NCH];
	logic [1:0] fn_w [NCH];
	logic   cap_fire_w [NCH];
	logic   cmp_out_q [NCH];
	logic   pls_out_q [NCH];

	// pin function fields, one two-bit field per channel
	always_ff @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
			port0_function_select_high_q <= `RST_BYTE;
		else if (clk_en_in && wr_fn)
			port0_function_select_high_q <= reg_wdata_in & `MASK_PORT_FN;
	end

	// sticky events; an event beats a clear in the same cycle
	always_ff @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			match_flag_q <= 3'h0;
			cap_flag_q   <= 3'h0;
		end
		else if (clk_en_in)
		begin
			match_flag_q <= (match_flag_q & ~(wr_stat ? reg_wdata_in[2:0] : 3'h0))
				| {match_w[2], match_w[1], match_w[0]};
			cap_flag_q <= (cap_flag_q & ~(wr_stat ? reg_wdata_in[5:3] : 3'h0))
				| {cap_fire_w[2], cap_fire_w[1], cap_fire_w[0]};
		end
	end

	// =====================================
	// channels

	for (genvar i = 0; i < NCH; i++)
	begin : g_ch
		timer_chan_if cif();

		wire        sel   = chan_hit && (ch_idx == 2'(i));
		wire [7:0]  wr    = (reg_wr_in && sel) ? slot_dec : 8'h00;
		wire [2:0]  ck    = ctrl_lo_q[i][`CTRL_CK_HI:`CTRL_CK_LO];
		wire        mode_cap = (cif.mode == MODE_CAPTURE);
		wire        alt_tick;
		wire        trig  = pin_rise[2 + i];

		// eighth clock option differs per channel
		if (i == 0)
		begin : g_alt_c
			assign alt_tick = ext_tick;
		end
		else if (i == 1)
		begin : g_alt_d
			assign alt_tick = match_w[0];
		end
		else
		begin : g_alt_e
			assign alt_tick = rc_tick;
		end

		// channel control and clock multiplexer
		assign fn_w[i]       = port0_function_select_high_q[2*i+1 -: 2];
		assign cif.enable    = ctrl_hi_q[i][`CTRL_EN_BIT];
		assign cif.mode      = mode_e'(ctrl_hi_q[i][`CTRL_MODE_HI:`CTRL_MODE_LO]);
		assign cif.tick      = (ck == 3'h7) ? alt_tick : pre_tick(pre_q, div_log(i, ck));
		assign cif.a_data    = a_q[i];
		assign cif.b_data    = b_q[i];
		assign count_w[i]    = cif.count;
		assign match_w[i]    = cif.match;
		assign cmp_w[i]      = cif.cmp_level;
		assign pls_w[i]      = cif.pulse_level;
		assign cap_fire_w[i] = cif.enable && mode_cap && (fn_w[i] == `FN_CAPTURE) && trig;

		timer_channel u_chan (
			.sys_clk_in (sys_clk_in),
			.rst_in     (rst_in),
			.clk_en_in  (clk_en_in),
			.bus        (cif.chan)
		);

		// control halves and A data bytes
		always_ff @(posedge sys_clk_in or posedge rst_in)
		begin
			if (rst_in)
			begin
				ctrl_hi_q[i] <= `RST_BYTE;
				ctrl_lo_q[i] <= `RST_BYTE;
				a_q[i]       <= `RST_A_WORD;
			end
			else if (clk_en_in)
			begin
				if (wr[`OFF_CTRL_HI])
					ctrl_hi_q[i] <= reg_wdata_in & `MASK_CTRL_HI;
				if (wr[`OFF_CTRL_LO])
					ctrl_lo_q[i] <= reg_wdata_in & `MASK_CTRL_LO;
				if (wr[`OFF_A_HI])
					a_q[i][15:8] <= reg_wdata_in;
				if (wr[`OFF_A_LO])
					a_q[i][7:0] <= reg_wdata_in;
			end
		end

		// B data: capture takes priority over a software byte write
		always_ff @(posedge sys_clk_in or posedge rst_in)
		begin
			if (rst_in)
				b_q[i] <= `RST_WORD;
			else if (clk_en_in)
			begin
				if (cap_fire_w[i])
					b_q[i] <= count_w[i];
				else if (wr[`OFF_B_HI])
					b_q[i][15:8] <= reg_wdata_in;
				else if (wr[`OFF_B_LO])
					b_q[i][7:0] <= reg_wdata_in;
			end
		end

		// pin drivers, gated by the pin function field
		always_ff @(posedge sys_clk_in or posedge rst_in)
		begin
			if (rst_in)
			begin
				cmp_out_q[i] <= 1'b0;
				pls_out_q[i] <= 1'b0;
			end
			else if (clk_en_in)
			begin
				cmp_out_q[i] <= cmp_w[i] && (fn_w[i] == `FN_OUTPUT);
				pls_out_q[i] <= pls_w[i] && (fn_w[i] == `FN_OUTPUT);
			end
		end
	end

	// =====================================
	// read path

	// one channel's register slot
	function automatic byte_t chan_read(input int ch, input logic [2:0] s);
		byte_t r;
		r = 8'h00;
		case (s)
			`OFF_CTRL_HI: r = ctrl_hi_q[ch];
			`OFF_CTRL_LO: r = ctrl_lo_q[ch];
			`OFF_A_HI:    r = a_q[ch][15:8];
			`OFF_A_LO:    r = a_q[ch][7:0];
			`OFF_B_HI:    r = b_q[ch][15:8];
			`OFF_B_LO:    r = b_q[ch][7:0];
			`OFF_CNT_HI:  r = count_w[ch][15:8];
			`OFF_CNT_LO:  r = count_w[ch][7:0];
			default:      r = 8'h00;
		endcase
		return r;
	endfunction

	// status byte: capture flags above match flags
	wire [7:0] status_w = {2'h0, cap_flag_q, match_flag_q};

	// read selection; unmapped addresses read zero
	wire [7:0] rd_chan = chan_read(int'(ch_idx), slot);
	wire [7:0] rd_mux  = chan_hit ? rd_chan
		: (reg_addr_in == `OFF_PORT_FN) ? port0_function_select_high_q
		: (reg_addr_in == `OFF_STATUS)  ? status_w
		: 8'h00;

	byte_t rdata_q;

	// read data stands only in the cycle after the strobe
	always_ff @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
			rdata_q <= 8'h00;
		else if (clk_en_in)
			rdata_q <= reg_rd_in ? rd_mux : 8'h00;
	end

	// =====================================
	// outputs

	assign reg_rdata_out      = rdata_q;
	assign chan_c_compare_out = cmp_out_q[0];
	assign chan_d_compare_out = cmp_out_q[1];
	assign chan_e_compare_out = cmp_out_q[2];
	assign chan_c_pulse_out   = pls_out_q[0];
	assign chan_d_pulse_out   = pls_out_q[1];
	assign chan_e_pulse_out   = pls_out_q[2];

endmodule

// *** test/triple_timer_properties.sv ***
/*
 * Concurrent checks on the ports of the triple timer.
 * Assumes a bind onto triple_timer and a single system clock domain.
 */
`timescale 1ns/1ps
module triple_timer_properties (
	// clock, reset, enable
	input wire logic             sys_clk_in,
	input wire logic             rst_in,
	input wire logic             clk_en_in,
	// register port
	input wire logic [7:0]       reg_addr_in,
	input wire timer_pkg::byte_t reg_wdata_in,
	input wire logic             reg_wr_in,
	input wire logic             reg_rd_in,
	input wire timer_pkg::byte_t reg_rdata_out,
	// waveform pins
	input wire logic             chan_c_compare_out,
	input wire logic             chan_d_compare_out,
	input wire logic             chan_e_compare_out,
	input wire logic             chan_c_pulse_out,
	input wire logic             chan_d_pulse_out,
	input wire logic             chan_e_pulse_out
);
	import timer_pkg::*;

	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);

	// =====================================
	// helpers
	// a read that the port really takes, and the six pins as one group
	wire logic       rd_take = reg_rd_in && clk_en_in;
	wire logic [5:0] pins    = {chan_e_pulse_out, chan_d_pulse_out, chan_c_pulse_out,
		chan_e_compare_out, chan_d_compare_out, chan_c_compare_out};

	// =====================================
	// register port
	property p_rdata_idle;
		$past(clk_en_in) && !$past(reg_rd_in) |-> reg_rdata_out == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero outside a read");
	property p_unmapped;
		rd_take && reg_addr_in > 8'h19 |=> reg_rdata_out == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_ctrl_hi_rsv;
		rd_take && reg_addr_in < 8'h18 && reg_addr_in[2:0] == 3'h0 |=> (reg_rdata_out & 8'h4F) == 8'h00;
	endproperty
	a_ctrl_hi_rsv: assert property (p_ctrl_hi_rsv) else $error("control high spare bits set");
	property p_ctrl_lo_rsv;
		rd_take && reg_addr_in < 8'h18 && reg_addr_in[2:0] == 3'h1 |=> reg_rdata_out[7:3] == 5'h00;
	endproperty
	a_ctrl_lo_rsv: assert property (p_ctrl_lo_rsv) else $error("control low spare bits set");
	property p_port_rsv;
		rd_take && reg_addr_in == 8'h18 |=> reg_rdata_out[7:6] == 2'h0;
	endproperty
	a_port_rsv: assert property (p_port_rsv) else $error("pin function spare bits set");
	property p_stat_rsv;
		rd_take && reg_addr_in == 8'h19 |=> reg_rdata_out[7:6] == 2'h0;
	endproperty
	a_stat_rsv: assert property (p_stat_rsv) else $error("status spare bits set");
	property p_a_readback;
		reg_wr_in && clk_en_in && reg_addr_in < 8'h18 && reg_addr_in[2:1] == 2'h1
			##1 rd_take && !reg_wr_in && $stable(reg_addr_in) |=> reg_rdata_out == $past(reg_wdata_in, 2);
	endproperty
	a_a_readback: assert property (p_a_readback) else $error("A data read back wrong");

	// =====================================
	// freeze
	property p_freeze;
		!clk_en_in |=> $stable(reg_rdata_out) && $stable(pins);
	endproperty
	a_freeze: assert property (p_freeze) else $error("outputs moved while clock enable low");
endmodule

// *** test/pin_model.sv ***
/*
 * Far side pins of the timer: count clocks and capture triggers.
 * Assumes the pins are asynchronous to the system clock.
 */
`timescale 1ns/1ps
module pin_model (
	// count clock pins
	output logic       ext_clk_out,
	output logic       rc_clk_out,
	// capture triggers c, d, e
	output logic [2:0] trig_out
);
	// idle levels at time zero
	initial
	begin
		ext_clk_out = 1'b0;
		rc_clk_out = 1'b0;
		trig_out = 3'h0;
	end

	// free running count clocks, both well below half the system clock
	always #37 ext_clk_out = ~ext_clk_out;
	always #29 rc_clk_out = ~rc_clk_out;

	// one rising edge on the chosen triggers, held long enough to pass the synchronisers
	task fire(input logic [2:0] which);
		trig_out = which;
		#40;
		trig_out = 3'h0;
	endtask
endmodule

// *** test/triple_timer_tb.sv ***
/*
 * Self-checking bench for the triple timer, driving its register port and pins.
 * Assumes pin_model and triple_timer_properties are compiled beside the design.
 */
`timescale 1ns/1ps
module triple_timer_tb;
	import timer_pkg::*;

	// =====================================
	// signals
	logic       sys_clk_in;
	logic       rst_in;
	logic       clk_en_in;
	logic [7:0] reg_addr_in;
	byte_t      reg_wdata_in;
	logic       reg_wr_in;
	logic       reg_rd_in;
	byte_t      reg_rdata_out;
	byte_t      seen;
	logic       ext_clk;
	logic       rc_clk;
	logic [2:0] trig;
	logic [5:0] pins;
	int         fails;
	int         check_count;

	triple_timer triple_timer_inst (.sys_clk_in, .rst_in, .clk_en_in, .reg_addr_in, .reg_wdata_in,
		.reg_wr_in, .reg_rd_in, .reg_rdata_out, .chan_c_external_count_clock_in(ext_clk),
		.internal_fast_rc_clock_in(rc_clk), .chan_c_capture_trigger_in(trig[0]),
		.chan_d_capture_trigger_in(trig[1]), .chan_e_capture_trigger_in(trig[2]),
		.chan_c_compare_out(pins[0]), .chan_d_compare_out(pins[1]), .chan_e_compare_out(pins[2]),
		.chan_c_pulse_out(pins[3]), .chan_d_pulse_out(pins[4]), .chan_e_pulse_out(pins[5]));
	pin_model pin_model_inst (.ext_clk_out(ext_clk), .rc_clk_out(rc_clk), .trig_out(trig));

	// 125 MHz system clock
	initial
	begin
		sys_clk_in = 1'b0;
		forever #4 sys_clk_in = ~sys_clk_in;
	end

	// =====================================
	// compare and bus tasks
	task check_byte(input byte_t got, input byte_t exp, input string what);
		check_count++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task check_bit(input logic got, input logic exp, input string what);
		check_count++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED %0t %s got %b expected %b", $time, what, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input byte_t d);
		reg_wr_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge sys_clk_in);
		reg_wr_in <= 1'b0;
		@(posedge sys_clk_in);
	endtask
	task rd(input logic [7:0] a);
		reg_rd_in <= 1'b1;
		reg_addr_in <= a;
		@(posedge sys_clk_in);
		reg_rd_in <= 1'b0;
		#1 seen = reg_rdata_out;
		@(posedge sys_clk_in);
	endtask
	// write then read the same place with no gap
	task wr_rd(input logic [7:0] a, input byte_t d);
		reg_wr_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge sys_clk_in);
		reg_wr_in <= 1'b0;
		reg_rd_in <= 1'b1;
		@(posedge sys_clk_in);
		reg_rd_in <= 1'b0;
		#1 seen = reg_rdata_out;
		@(posedge sys_clk_in);
	endtask
	// cycles between two successive changes of one pin
	task gap(input int idx, output byte_t n);
		logic v;
		int   k;
		v = pins[idx];
		k = 0;
		while (pins[idx] === v && k < 200)
		begin
			@(posedge sys_clk_in);
			#1 k++;
		end
		v = pins[idx];
		n = 8'h00;
		while (pins[idx] === v && n < 8'hC8)
		begin
			@(posedge sys_clk_in);
			#1 n++;
		end
	endtask

	// =====================================
	// scenarios
	task t_regs;
		rd(8'h02);
		check_byte(seen, 8'hFF, "A high reset");
		rd(8'h13);
		check_byte(seen, 8'hFF, "A low reset");
		rd(8'h0C);
		check_byte(seen, 8'h00, "B high reset");
		rd(8'h40);
		check_byte(seen, 8'h00, "unmapped read");
		wr(8'h00, 8'hFF);
		rd(8'h00);
		check_byte(seen, 8'hB0, "control high mask");
		wr(8'h09, 8'hFF);
		rd(8'h09);
		check_byte(seen, 8'h07, "control low mask");
		wr_rd(8'h18, 8'hFF);
		check_byte(seen, 8'h3F, "pin function mask");
		wr_rd(8'h03, 8'h5A);
		check_byte(seen, 8'h5A, "A low read back");
		wr(8'h00, 8'h00);
		wr(8'h09, 8'h00);
		$display("register test done");
	endtask
	task t_timer;
		byte_t n;
		wr(8'h03, 8'h02);
		wr(8'h02, 8'h00);
		wr(8'h0B, 8'h01);
		wr(8'h0A, 8'h00);
		wr(8'h09, 8'h07);
		wr(8'h08, 8'h80);
		wr(8'h00, 8'h80);
		gap(0, n);
		check_byte(n, 8'h03, "c compare spacing");
		gap(1, n);
		check_byte(n, 8'h06, "d cascade spacing");
		check_bit(pins[2], 1'b0, "e compare idle");
		rd(8'h19);
		check_byte(seen & 8'h03, 8'h03, "match flags");
		clk_en_in <= 1'b0;
		repeat (5) @(posedge sys_clk_in);
		clk_en_in <= 1'b1;
		wr(8'h00, 8'h00);
		wr(8'h08, 8'h00);
		repeat (3) @(posedge sys_clk_in);
		#1 check_bit(pins[0], 1'b0, "c compare cleared");
		$display("timer test done");
	endtask
	task t_capture;
		wr(8'h18, 8'h00);
		wr(8'h03, 8'hFF);
		wr(8'h0B, 8'hFF);
		wr(8'h09, 8'h00);
		for (int c = 0; c < 3; c++)
			wr(8'(c * 8), 8'h90);
		repeat (20) @(posedge sys_clk_in);
		pin_model_inst.fire(3'h7);
		repeat (10) @(posedge sys_clk_in);
		for (int c = 0; c < 3; c++)
		begin
			rd(8'(c * 8 + 5));
			check_bit(seen > 8'h10 && seen < 8'h30, 1'b1, "captured count");
			rd(8'(c * 8 + 4));
			check_byte(seen, 8'h00, "captured high");
			wr(8'(c * 8), 8'h00);
		end
		rd(8'h19);
		check_byte(seen & 8'h38, 8'h38, "capture flags");
		$display("capture test done");
	endtask
	task t_pulse(input int c, input byte_t ctrl);
		logic  prev;
		byte_t n;
		wr(8'h18, 8'h3F);
		wr(8'(c * 8 + 2), 8'h00);
		wr(8'(c * 8 + 3), 8'h04);
		wr(8'(c * 8 + 5), 8'h02);
		wr(8'(c * 8), ctrl);
		prev = 1'b0;
		n = 8'h00;
		repeat (60)
		begin
			@(posedge sys_clk_in);
			#1 if (pins[3 + c] === 1'b1 && prev === 1'b0)
				n++;
			prev = pins[3 + c];
		end
		if (ctrl[4])
			check_bit(n > 8'h08, 1'b1, "repeat rises");
		else
			check_byte(n, 8'h01, "one-shot rises");
		wr(8'(c * 8), 8'h00);
		$display("pulse test done");
	endtask
	// prescaler taps and pin clocks, each seen as the spacing of compare toggles with A at zero
	task t_clocks;
		byte_t n;
		wr(8'h18, 8'h3F);
		for (int c = 0; c < 3; c++)
		begin
			wr(8'(c * 8 + 2), 8'h00);
			wr(8'(c * 8 + 3), 8'h00);
			wr(8'(c * 8 + 1), 8'h04);
			wr(8'(c * 8), 8'h80);
		end
		gap(0, n);
		check_byte(n, 8'h40, "c prescaled spacing");
		gap(1, n);
		check_byte(n, 8'h20, "d prescaled spacing");
		gap(2, n);
		check_byte(n, 8'h20, "e prescaled spacing");
		wr(8'h01, 8'h07);
		wr(8'h11, 8'h07);
		gap(0, n);
		check_bit(n >= 8'h09 && n <= 8'h0A, 1'b1, "c count pin spacing");
		gap(2, n);
		check_bit(n >= 8'h07 && n <= 8'h08, 1'b1, "e rc pin spacing");
		for (int c = 0; c < 3; c++)
			wr(8'(c * 8), 8'h00);
		$display("clock select test done");
	endtask

	// =====================================
	// verdict, watchdog and main sequence
	task complete_run;
		$display("checks %0d failures %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// cut a hang short well after the tests should have ended
	initial
	begin
		#50000;
		fails++;
		complete_run;
	end
	// reset, then the scenarios in turn
	initial
	begin
		rst_in = 1'b1;
		clk_en_in = 1'b1;
		reg_addr_in = 8'h00;
		reg_wdata_in = 8'h00;
		reg_wr_in = 1'b0;
		reg_rd_in = 1'b0;
		fails = 0;
		check_count = 0;
		repeat (10) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		@(posedge sys_clk_in);
		t_regs;
		t_timer;
		t_capture;
		t_pulse(0, 8'hB0);
		t_pulse(1, 8'hA0);
		t_pulse(2, 8'hA0);
		t_pulse(2, 8'hB0);
		t_clocks;
		complete_run;
	end
endmodule

bind triple_timer triple_timer_properties triple_timer_properties_inst (.sys_clk_in, .rst_in, .clk_en_in,
	.reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .chan_c_compare_out,
	.chan_d_compare_out, .chan_e_compare_out, .chan_c_pulse_out, .chan_d_pulse_out, .chan_e_pulse_out);
